/* File: hdl/alarm_regs_consts.vh */
`ifndef ALARM_REGS_CONSTS_VH
`define ALARM_REGS_CONSTS_VH
`define ADDR_W 8
`define OFS_MM 8'h00
`define OFS_HH 8'h04
`define OFS_DATE 8'h08
`define OFS_KEY0 8'h0c
`define OFS_KEY1 8'h10
`define OFS_CTRL 8'h14
`define OFS_STAT 8'h18
`define OFS_MASK 8'h1c
`define OFS_LOCK 8'h20
`define KEY0_VAL 32'h1234_5678
`define KEY1_VAL 32'h9abc_def0
`define RST_MM 7'h00
`define RST_HH 8'h00
`define RST_DATE 6'h01
`define RST_CTRL 2'h0
`define MM_W 7
`define HH_W 8
`define DATE_W 6
`define HH_PM_BIT 7
`define CTRL_EN_BIT 0
`define CTRL_12H_BIT 1
`define STAT_ALARM_BIT 0
`define STAT_REJ_BIT 1
`define STAT_W 2
`endif

/* File: hdl/bcd_digit_check.v */
`timescale 1ns/1ps
module bcd_digit_check #(
   parameter [3:0] MAX_DIGIT = 4'h9
) (
   input wire [3:0] digit_in,
   output wire ok_out
);
   // A digit is accepted only if it is a decimal value within its limit.
   assign ok_out = (digit_in <= 4'h9) && (digit_in <= MAX_DIGIT);
endmodule

/* File: hdl/unlock_keys.v */
`timescale 1ns/1ps
`include "alarm_regs_consts.vh"
module unlock_keys (
   input wire sys_clk_in,
   input wire resetn_in,
   input wire wr_in,
   input wire [`ADDR_W-1:0] addr_in,
   input wire [31:0] wdata_in,
   output wire unlocked_out
);
   reg key0_ok_q;
   reg unlocked_q;
   // Key 0 then key 1 opens; any wrong key value closes again.
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         key0_ok_q <= 1'b0;
         unlocked_q <= 1'b0;
      end else if (wr_in && addr_in == `OFS_KEY0) begin
         key0_ok_q <= (wdata_in == `KEY0_VAL);
         if (wdata_in != `KEY0_VAL) begin
            unlocked_q <= 1'b0;
         end
      end else if (wr_in && addr_in == `OFS_KEY1) begin
         unlocked_q <= key0_ok_q && (wdata_in == `KEY1_VAL);
         key0_ok_q <= 1'b0;
      end
   end
   assign unlocked_out = unlocked_q;
endmodule

/* File: hdl/alarm_time_regs.v */
`timescale 1ns/1ps
`include "alarm_regs_consts.vh"
module alarm_time_regs (
   input wire sys_clk_in,
   input wire resetn_in,
   input wire [`ADDR_W-1:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   input wire [`MM_W-1:0] cal_mm_in,
   input wire [`HH_W-1:0] cal_hh_in,
   input wire [`DATE_W-1:0] cal_date_in,
   input wire cal_tick_in,
   output wire alarm_match_out,
   output wire irq_out
);
   reg [`MM_W-1:0] mm_q;
   reg [`HH_W-1:0] hh_q;
   reg [`DATE_W-1:0] date_q;
   reg [1:0] ctrl_q;
   reg [`STAT_W-1:0] stat_q;
   reg [`STAT_W-1:0] mask_q;
   reg [`STAT_W-1:0] stat_d;
   reg [31:0] rdata_d;
   wire unlocked;
   wire [5:0] dig_ok;
   wire wr_mm;
   wire wr_hh;
   wire wr_date;
   wire mm_ok;
   wire hh_ok;
   wire date_ok;
   wire rejected;
   wire hit;

   unlock_keys u_keys (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .wr_in(wr_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .unlocked_out(unlocked)
   );

   bcd_digit_check #(.MAX_DIGIT(4'h5)) u_mm_t (.digit_in({1'b0, wdata_in[6:4]}), .ok_out(dig_ok[0]));
   bcd_digit_check #(.MAX_DIGIT(4'h9)) u_mm_u (.digit_in(wdata_in[3:0]), .ok_out(dig_ok[1]));
   bcd_digit_check #(.MAX_DIGIT(4'h2)) u_hh_t (.digit_in({2'b00, wdata_in[5:4]}), .ok_out(dig_ok[2]));
   bcd_digit_check #(.MAX_DIGIT(4'h9)) u_hh_u (.digit_in(wdata_in[3:0]), .ok_out(dig_ok[3]));
   bcd_digit_check #(.MAX_DIGIT(4'h3)) u_dt_t (.digit_in({2'b00, wdata_in[5:4]}), .ok_out(dig_ok[4]));
   bcd_digit_check #(.MAX_DIGIT(4'h9)) u_dt_u (.digit_in(wdata_in[3:0]), .ok_out(dig_ok[5]));

   // Hour and date add whole-value range checks on top of per-digit BCD checks; minutes use digit checks only.
   assign mm_ok = dig_ok[0] && dig_ok[1];
   assign hh_ok = dig_ok[2] && dig_ok[3] && (wdata_in[5:0] <= 6'h24);
   assign date_ok = dig_ok[4] && dig_ok[5] && (wdata_in[5:0] <= 6'h31)
      && (wdata_in[5:0] != 6'h00);

   assign wr_mm = wr_in && (addr_in == `OFS_MM) && unlocked && mm_ok;
   assign wr_hh = wr_in && (addr_in == `OFS_HH) && unlocked && hh_ok;
   assign wr_date = wr_in && (addr_in == `OFS_DATE) && unlocked && date_ok;
   assign rejected = wr_in && !unlocked
      && (addr_in == `OFS_MM || addr_in == `OFS_HH || addr_in == `OFS_DATE);

   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mm_q <= `RST_MM;
         hh_q <= `RST_HH;
         date_q <= `RST_DATE;
         ctrl_q <= `RST_CTRL;
         mask_q <= {`STAT_W{1'b0}};
      end else begin
         if (wr_mm) begin
            mm_q <= wdata_in[`MM_W-1:0];
         end
         if (wr_hh) begin
            hh_q <= {wdata_in[`HH_PM_BIT], 1'b0, wdata_in[5:0]};
         end
         if (wr_date) begin
            date_q <= wdata_in[`DATE_W-1:0];
         end
         if (wr_in && addr_in == `OFS_CTRL) begin
            ctrl_q <= wdata_in[1:0];
         end
         if (wr_in && addr_in == `OFS_MASK) begin
            mask_q <= wdata_in[`STAT_W-1:0];
         end
      end
   end

   // Meridiem bit is compared only in 12-hour mode.
   assign hit = (cal_mm_in == mm_q) && (cal_date_in == date_q)
      && (cal_hh_in[5:0] == hh_q[5:0])
      && (!ctrl_q[`CTRL_12H_BIT] || cal_hh_in[`HH_PM_BIT] == hh_q[`HH_PM_BIT]);
   assign alarm_match_out = cal_tick_in && hit && ctrl_q[`CTRL_EN_BIT];

   // Status is write-one-to-clear; a new event in the same cycle wins.
   always @* begin
      stat_d = stat_q;
      if (wr_in && addr_in == `OFS_STAT) begin
         stat_d = stat_q & ~wdata_in[`STAT_W-1:0];
      end
      if (alarm_match_out) begin
         stat_d[`STAT_ALARM_BIT] = 1'b1;
      end
      if (rejected) begin
         stat_d[`STAT_REJ_BIT] = 1'b1;
      end
   end

   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stat_q <= {`STAT_W{1'b0}};
      end else begin
         stat_q <= stat_d;
      end
   end

   assign irq_out = |(stat_q & mask_q);

   // Reserved bits read zero; unmapped addresses read zero.
   always @* begin
      rdata_d = 32'h0000_0000;
      case (addr_in)
         `OFS_MM: rdata_d[`MM_W-1:0] = mm_q;
         `OFS_HH: rdata_d[`HH_W-1:0] = hh_q;
         `OFS_DATE: rdata_d[`DATE_W-1:0] = date_q;
         `OFS_CTRL: rdata_d[1:0] = ctrl_q;
         `OFS_STAT: rdata_d[`STAT_W-1:0] = stat_q;
         `OFS_MASK: rdata_d[`STAT_W-1:0] = mask_q;
         `OFS_LOCK: rdata_d[0] = unlocked;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_in) begin
         rdata_out <= rdata_d;
      end else begin
         rdata_out <= 32'h0000_0000;
      end
   end
endmodule

/* File: dv/alarm_time_regs_props.sv */
`timescale 1ns/1ps
`include "alarm_regs_consts.vh"
module alarm_time_regs_props (
   input wire sys_clk_in,
   input wire resetn_in,
   input wire [`ADDR_W-1:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [31:0] rdata_out,
   input wire [`MM_W-1:0] cal_mm_in,
   input wire [`HH_W-1:0] cal_hh_in,
   input wire [`DATE_W-1:0] cal_date_in,
   input wire cal_tick_in,
   input wire alarm_match_out,
   input wire irq_out
);
   reg key_q;
   wire rm = rd_in && addr_in == `OFS_MM;
   wire rh = rd_in && addr_in == `OFS_HH;
   wire rdt = rd_in && addr_in == `OFS_DATE;
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         key_q <= 1'b0;
      else if (wr_in && addr_in == `OFS_KEY1)
         key_q <= 1'b1;
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   a_digit_bcd: assert property ((rm || rh || rdt) |=> rdata_out[3:0] <= 4'h9)
      else $error("units digit");
   a_mm_field: assert property (rm |=> rdata_out[31:7] == 0 && rdata_out[6:4] <= 3'h5)
      else $error("minute field");
   a_hh_field: assert property (rh |=> rdata_out[31:8] == 0 && !rdata_out[6]
      && rdata_out[5:0] <= 6'h24) else $error("hour field");
   a_date_field: assert property (rdt |=> rdata_out[31:6] == 0
      && rdata_out[5:0] != 0 && rdata_out[5:0] <= 6'h31) else $error("day field");
   a_lock_held: assert property (rd_in && addr_in == `OFS_LOCK && !key_q |=> !rdata_out[0])
      else $error("unlock early");
   a_match_tick: assert property (alarm_match_out |-> cal_tick_in)
      else $error("match no tick");
   a_irq_reset: assert property ($rose(resetn_in) |-> !irq_out)
      else $error("irq at reset");
   a_rd_idle: assert property (!rd_in |=> rdata_out == 0)
      else $error("rdata idle");
endmodule
bind alarm_time_regs alarm_time_regs_props u_props (.*);

/* File: dv/alarm_time_regs_tb_top.sv */
`timescale 1ns/1ps
`include "alarm_regs_consts.vh"
module alarm_time_regs_tb_top;
   logic sys_clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, cal_tick_in = 0;
   logic [`ADDR_W-1:0] addr_in = 0;
   logic [31:0] wdata_in = 0;
   logic [`MM_W-1:0] cal_mm_in = 0;
   logic [`HH_W-1:0] cal_hh_in = 0;
   logic [`DATE_W-1:0] cal_date_in = 0;
   wire [31:0] rdata_out;
   wire alarm_match_out, irq_out;
   int n_mismatch = 0, checked = 0, cyc = 0, i;
   logic [7:0] ta [12] = '{0, 0, 0, 0, 4, 4, 4, 4, 8, 8, 8, 8};
   logic [9:0] td [12] = '{'h59, 'h5a, 'h60, 'h30, 'h24, 'h25, 'hc5, 'h12, 'h31, 'h32, 0, 'h115};
   logic [7:0] te [12] = '{'h59, 'h59, 'h59, 'h30, 'h24, 'h24, 'h85, 'h12, 'h31, 'h31, 'h31, 'h15};
   alarm_time_regs uut (.*);
   always #2.5 sys_clk_in = ~sys_clk_in;
   task chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("ERROR %s exp %h got %h", n, e, g);
         n_mismatch++;
      end
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task rd(logic [7:0] a, logic [31:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      @(negedge sys_clk_in);
      chk("rdata", e, rdata_out);
      @(posedge sys_clk_in);
   endtask
   task tick(logic [7:0] h, logic e);
      cal_hh_in <= h;
      cal_tick_in <= 1'b1;
      @(negedge sys_clk_in);
      chk("match", e, alarm_match_out);
      @(posedge sys_clk_in);
      cal_tick_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task chk_irq(logic e);
      @(negedge sys_clk_in);
      chk("irq", e, irq_out);
      @(posedge sys_clk_in);
   endtask
   task finish_test;
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      @(posedge sys_clk_in);
      rd(`OFS_MM, 32'h0);
      rd(`OFS_HH, 32'h0);
      rd(`OFS_DATE, 32'h1);
      wr(`OFS_MM, 32'h45);
      rd(`OFS_MM, 32'h0);
      rd(`OFS_STAT, 32'h2);
      wr(`OFS_STAT, 32'h2);
      wr(`OFS_KEY0, `KEY0_VAL);
      wr(`OFS_KEY1, `KEY1_VAL);
      rd(`OFS_LOCK, 32'h1);
      rd(8'h40, 32'h0);
      for (i = 0; i < 12; i++) begin
         wr(ta[i], td[i]);
         rd(ta[i], te[i]);
      end
      wr(`OFS_CTRL, 32'h1);
      wr(`OFS_MASK, 32'h1);
      cal_date_in <= 6'h15;
      for (i = 0; i < 2; i++) begin
         cal_mm_in <= i[0] ? 7'h30 : 7'h31;
         tick(8'h12, i[0]);
         chk_irq(i[0]);
      end
      tick(8'h92, 1'b1);
      wr(`OFS_CTRL, 32'h3);
      tick(8'h92, 1'b0);
      tick(8'h12, 1'b1);
      wr(`OFS_HH, 32'h92);
      rd(`OFS_HH, 32'h92);
      tick(8'h92, 1'b1);
      tick(8'h12, 1'b0);
      wr(`OFS_CTRL, 32'h2);
      tick(8'h92, 1'b0);
      rd(`OFS_STAT, 32'h1);
      wr(`OFS_MASK, 32'h0);
      chk_irq(1'b0);
      wr(`OFS_MASK, 32'h1);
      chk_irq(1'b1);
      wr(`OFS_STAT, 32'h1);
      chk_irq(1'b0);
      resetn_in <= 1'b0;
      @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      @(posedge sys_clk_in);
      chk_irq(1'b0);
      rd(`OFS_LOCK, 32'h0);
      rd(`OFS_HH, 32'h0);
      rd(`OFS_DATE, 32'h1);
      wr(`OFS_KEY1, `KEY1_VAL);
      rd(`OFS_LOCK, 32'h0);
      wr(`OFS_KEY0, `KEY0_VAL);
      wr(`OFS_KEY0, 32'h0);
      wr(`OFS_KEY1, `KEY1_VAL);
      rd(`OFS_LOCK, 32'h0);
      wr(`OFS_DATE, 32'h22);
      rd(`OFS_DATE, 32'h1);
      finish_test;
   end
endmodule
